/* File: design/hop_pkg.sv */
// Constants and types for the home offset and position preset block.
// Assumes a single 10 MHz control clock and an active-low asynchronous reset.
// Functional notes
// - Offset writes accepted anytime, applied at events
// - Seven events trigger offset apply and preset
// - Home detect: internal zero, user equals offset
// - Plain preset: demand follows actual, plus offset
// - After homing, index position equals home offset
// - Incremental zero is power-on or home minus offset
// - Absolute zero is home minus home offset
// - Scale position is 48 bits from halves
// - Internal actual keeps low 32 bits, 8-bit high
// - Full-closed homing loads scale offsets with negated halves
// - User actual is gear product plus offset
// - Polarity 224 negates gear product
// - Overflow beyond 32 bits raises counter alarm
// - Multi-turn clear allowed with full-closed rotary scale
// - Backlash compensated by select, amount, time constant
// - Backlash portion shown only during transition
`default_nettype none
package hop_pkg;
    localparam logic [15:0] HOME_OFFSET_VALUE_ADDR = 16'h607c; // Home offset object index
    localparam logic [31:0] HOME_OFFSET_RESET = 32'h00000000; // Home offset after reset
    localparam logic [7:0] POLARITY_CW = 8'he0; // Polarity code, clockwise positive
    localparam int SCALE_HALF_W = 24; // Width of each scale half
    localparam int HIGH_INT_BITS = 8; // Significant high bits, internal
    localparam int HIGH_USER_BITS = 21; // Significant high bits, user
    localparam int GEAR_W = 16; // Gear reverse conversion width
    localparam int BL_TC_W = 16; // Backlash time constant width
    typedef enum logic [1:0] {
        HOP_BL_IDLE = 2'b00, // No compensation active
        HOP_BL_RAMP = 2'b01, // Compensation in transition
        HOP_BL_DONE = 2'b10 // Compensation complete
    } hop_bl_state_t;
endpackage : hop_pkg
`default_nettype wire

/* File: design/hop_wide_mul.sv */
// Registered signed multiply of the corrected scale sum by the gear value.
// Assumes operands are stable for one cycle; result appears the next cycle.
`default_nettype none
module hop_wide_mul
    import hop_pkg::*;
(
    input wire logic sys_clk_in, // Control clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic signed [47:0] a_in, // Corrected scale sum
    input wire logic signed [GEAR_W:0] b_in, // Gear value, zero extended
    output logic signed [64:0] p_out // Registered product
);
    // Product register
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            p_out <= '0;
        end else begin
            p_out <= 65'(a_in) * 65'(b_in); // Operands widened first so no bit is lost
        end
    end
endmodule : hop_wide_mul
`default_nettype wire

/* File: design/hop_home_offset.sv */
// Home offset preset, absolute scale assembly, overflow and backlash logic.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk_in.
// Assumes scale halves, encoder and settings are synchronous and settled.
// Assumes home_detect_in stands at the same edge as the event it qualifies.
// Positions are two's complement; the product path adds one cycle of latency.
`default_nettype none
module hop_home_offset
    import hop_pkg::*;
(
    input wire logic sys_clk_in, // Control clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic obj_wr_in, // Object write strobe
    input wire logic [15:0] obj_index_in, // Object index
    input wire logic [31:0] obj_wdata_in, // Object write data
    output logic [31:0] obj_rdata_out, // Home offset readback
    input wire logic ev_power_up_in, // Power-up event pulse
    input wire logic ev_init_to_preop_in, // Fieldbus Init to PreOP pulse
    input wire logic ev_homing_done_in, // Homing mode completed pulse
    input wire logic ev_multiturn_clear_in, // Multi-turn clear pulse
    input wire logic ev_tool_done_in, // Setup tool operation done
    input wire logic ev_pin_assign_in, // Pin assignment change pulse
    input wire logic command_error_alarm_in, // Command error alarm pulse
    input wire logic home_detect_in, // Home detected with event
    input wire logic full_closed_in, // Full-closed control selected
    input wire logic rotary_scale_in, // Scale is rotary
    input wire logic [SCALE_HALF_W-1:0] scale_high_in, // Scale high half
    input wire logic [SCALE_HALF_W-1:0] scale_low_in, // Scale low half
    input wire logic [31:0] encoder_pos_in, // Semi-closed encoder position
    input wire logic [GEAR_W-1:0] gear_reverse_in, // Gear reverse conversion
    input wire logic [7:0] direction_polarity_in, // Polarity setting
    input wire logic backlash_select_in, // Backlash compensation enable
    input wire logic [31:0] backlash_amount_in, // Backlash amount
    input wire logic [BL_TC_W-1:0] backlash_time_constant_in, // Ramp cycles
    input wire logic dir_change_in, // Motion direction reversal pulse
    output logic [31:0] internal_actual_position_out, // Internal actual
    output logic [31:0] internal_demand_position_out, // Internal demand
    output logic [31:0] user_actual_position_out, // User-unit actual
    output logic [31:0] user_demand_position_out, // User-unit demand
    output logic [31:0] feedback_position_out, // Reported feedback
    output logic [SCALE_HALF_W-1:0] scale_offset_high_out, // Scale offset high
    output logic [SCALE_HALF_W-1:0] scale_offset_low_out, // Scale offset low
    output logic multiturn_clear_out, // Multi-turn clear accepted
    output logic counter_overflow_alarm_out, // Counter overflow alarm
    output logic preset_done_out // Preset applied pulse
);
    logic [31:0] pending_offset; // Written, not yet applied
    logic [31:0] home_offset; // Active offset
    logic reflect; // Any reflection event
    logic [47:0] scale_sum; // Offset-corrected 48-bit sum
    logic signed [64:0] product; // Gear product
    logic signed [64:0] signed_prod; // After polarity
    logic prod_ovf; // Product out of 32 bits, or sum beyond 21 high bits
    logic [31:0] int_pos; // Internal position source
    logic [31:0] user_pos; // User position before backlash
    hop_bl_state_t bl_state; // Backlash state
    logic [BL_TC_W-1:0] bl_cnt; // Ramp counter
    logic [31:0] bl_portion; // Current compensation part
    logic [31:0] enc_zero; // Encoder reading at home
    logic [31:0] enc_rel; // Encoder relative to home
    logic [47:0] scale_off; // Scale offsets as one signed value
    logic sum_ovf; // Corrected sum beyond 21 high bits
    logic offset_wr; // Write hits the home offset

    // Any reflection event
    assign reflect = ev_power_up_in | ev_init_to_preop_in | ev_homing_done_in
        | ev_multiturn_clear_in | ev_tool_done_in | ev_pin_assign_in | command_error_alarm_in;

    // Write decode, shared by the register and its check
    assign offset_wr = obj_wr_in && (obj_index_in == HOME_OFFSET_VALUE_ADDR);

    // Pending offset written any time
    // Live coordinates are untouched until an event applies it
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pending_offset <= HOME_OFFSET_RESET;
        end else if (offset_wr) begin // Other indices are ignored
            pending_offset <= obj_wdata_in;
        end
    end

    // Active offset latched only on an event
    // Event in the same cycle as a write takes the older value
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            home_offset <= HOME_OFFSET_RESET;
        end else if (reflect) begin
            home_offset <= pending_offset;
        end
    end

    // Readback shows pending (written) value
    // Reads see a write two cycles after its strobe, before any event
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            obj_rdata_out <= HOME_OFFSET_RESET;
        end else begin
            obj_rdata_out <= pending_offset;
        end
    end

    // Scale offsets loaded with negated halves on homing
    // Semi-closed homing uses the encoder zero instead
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scale_offset_high_out <= '0;
            scale_offset_low_out <= '0;
        end else if (ev_homing_done_in && full_closed_in) begin
            scale_offset_high_out <= SCALE_HALF_W'(-scale_high_in);
            scale_offset_low_out <= SCALE_HALF_W'(-scale_low_in);
        end
    end

    // Encoder reading captured at home, semi-closed only
    // Without it the internal position would fall back to raw counts
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            enc_zero <= '0; // Power-on point is zero
        end else if (reflect && home_detect_in && !full_closed_in) begin
            enc_zero <= encoder_pos_in;
        end
    end

    // Encoder count relative to the home point
    assign enc_rel = encoder_pos_in - enc_zero;

    // Each offset half is a signed value of its own; the low one is
    // sign extended, so that its borrow reaches the high half
    assign scale_off = {scale_offset_high_out, 24'h0}
        + {{SCALE_HALF_W{scale_offset_low_out[SCALE_HALF_W-1]}}, scale_offset_low_out};
    // 48-bit corrected sum of scale and offsets
    assign scale_sum = {scale_high_in, scale_low_in} + scale_off;

    // Registered multiply keeps the long path out of one cycle
    // Product therefore lags the scale by one cycle, its alarm by two
    hop_wide_mul u_mul (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .a_in($signed(scale_sum)),
        .b_in($signed({1'b0, gear_reverse_in})),
        .p_out(product)
    );

    // Polarity applied to the gear product
    assign signed_prod = (direction_polarity_in == POLARITY_CW) ? 65'(-product) : product;
    // Result must fit in 32 signed bits; sign bits above must agree
    assign prod_ovf = (signed_prod[64:31] != {34{signed_prod[31]}})
        || sum_ovf;
    // Corrected sum keeps 21 signed high bits; negative positions are legal
    assign sum_ovf = scale_sum[47:HIGH_USER_BITS+SCALE_HALF_W-1]
        != {(48-HIGH_USER_BITS-SCALE_HALF_W+1){scale_sum[47]}};

    // Internal position: low 32 bits of scale sum, or encoder
    // Only 8 bits of the high half survive the cut to 32 bits
    assign int_pos = full_closed_in ? scale_sum[31:0] : enc_rel;
    // User position: gear product or encoder, plus active offset
    assign user_pos = (full_closed_in ? signed_prod[31:0] : enc_rel) + home_offset;

    // Sticky overflow alarm, cleared by reset only
    // Sticky so that a one-cycle overflow is never lost
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            counter_overflow_alarm_out <= 1'b0;
        end else if (full_closed_in && prod_ovf) begin
            counter_overflow_alarm_out <= 1'b1;
        end
    end

    // Position preset at reflection events
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            internal_actual_position_out <= '0;
            internal_demand_position_out <= '0;
            user_actual_position_out <= HOME_OFFSET_RESET;
            user_demand_position_out <= HOME_OFFSET_RESET;
        end else if (reflect && home_detect_in) begin
            // Home point becomes zero, user sees offset
            // Pending value, since the active offset updates this edge
            internal_actual_position_out <= '0;
            internal_demand_position_out <= '0;
            user_actual_position_out <= pending_offset;
            user_demand_position_out <= pending_offset;
        end else if (reflect) begin
            // Demand snaps to actual, user adds offset
            // Same pending value as the active offset takes now
            internal_actual_position_out <= int_pos;
            internal_demand_position_out <= int_pos;
            user_actual_position_out <= int_pos + pending_offset;
            user_demand_position_out <= int_pos + pending_offset;
        end else begin
            // Tracking between events
            // Demand positions hold until the next event
            internal_actual_position_out <= int_pos;
            user_actual_position_out <= user_pos;
        end
    end

    // Preset done pulse
    // One cycle after the event, in step with the new positions
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            preset_done_out <= 1'b0;
        end else begin
            preset_done_out <= reflect;
        end
    end

    // Multi-turn clear only under full-closed rotary scale
    // Refused silently in every other configuration
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            multiturn_clear_out <= 1'b0;
        end else begin
            multiturn_clear_out <= ev_multiturn_clear_in && full_closed_in && rotary_scale_in;
        end
    end

    // Backlash compensation state machine
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bl_state <= HOP_BL_IDLE;
            bl_cnt <= '0;
        end else begin
            case (bl_state)
                HOP_BL_IDLE: begin
                    // Wait for a reversal with compensation on
                    if (backlash_select_in && dir_change_in) begin
                        bl_state <= HOP_BL_RAMP;
                        bl_cnt <= backlash_time_constant_in;
                    end
                end
                HOP_BL_RAMP: begin
                    // Portion stands for the time constant in cycles, one cycle when it is zero
                    if (bl_cnt <= BL_TC_W'(1)) begin
                        bl_state <= HOP_BL_DONE;
                    end else begin
                        bl_cnt <= bl_cnt - BL_TC_W'(1);
                    end
                end
                HOP_BL_DONE: begin
                    // Portion removed; a new reversal rearms
                    if (backlash_select_in && dir_change_in) begin
                        bl_state <= HOP_BL_RAMP;
                        bl_cnt <= backlash_time_constant_in;
                    end
                end
                default: begin
                    // Unused code falls back to idle
                    bl_state <= HOP_BL_IDLE;
                end
            endcase
        end
    end

    // Portion appears only in transition
    assign bl_portion = (bl_state == HOP_BL_RAMP) ? backlash_amount_in : '0;

    // Feedback position with transient backlash portion
    // Registered, so the portion shows one cycle after the state
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            feedback_position_out <= '0;
        end else begin
            feedback_position_out <= user_pos + bl_portion;
        end
    end

    // Offset, preset, scale, alarm, multi-turn and backlash checks
    // Each guards one rule; labels name what they watch
    a_offset_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !reflect |=> home_offset == $past(home_offset))
        else $error("Offset changed without event");
    a_event_latch: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reflect |=> home_offset == $past(pending_offset))
        else $error("Offset not latched on event");
    a_home_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reflect && home_detect_in |=> internal_demand_position_out == 0
        && user_demand_position_out == home_offset)
        else $error("Home preset wrong");
    a_plain_preset: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reflect && !home_detect_in |=> internal_demand_position_out == internal_actual_position_out
        && user_demand_position_out == internal_actual_position_out + home_offset)
        else $error("Plain preset wrong");
    a_scale_neg: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ev_homing_done_in && full_closed_in |=> 24'(scale_offset_low_out + $past(scale_low_in)) == 0)
        else $error("Scale offset not negated");
    a_ovf_alarm: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        full_closed_in && prod_ovf |=> counter_overflow_alarm_out)
        else $error("Overflow alarm missed");
    a_mt_clear: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        multiturn_clear_out |-> $past(full_closed_in && rotary_scale_in))
        else $error("Multi-turn clear not allowed");
    a_bl_done: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        bl_state == HOP_BL_DONE && !dir_change_in |=> feedback_position_out == $past(user_pos))
        else $error("Backlash portion not removed");
    a_bl_start: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        bl_state == HOP_BL_IDLE && backlash_select_in && dir_change_in |=> bl_state == HOP_BL_RAMP)
        else $error("Backlash ramp not started");

    // Offset write lands and reads back two cycles on
    a_wr_readback: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        offset_wr |=> ##1 obj_rdata_out == $past(obj_wdata_in, 2))
        else $error("Offset write not read back");

    // Writes to other indices leave the offset alone
    a_wr_ignored: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        obj_wr_in && !offset_wr |=> pending_offset == $past(pending_offset))
        else $error("Foreign write changed offset");

    // Demand positions move only at events
    a_demand_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !reflect |=> $stable(internal_demand_position_out) && $stable(user_demand_position_out))
        else $error("Demand moved without event");

    // Every event reports its preset
    a_preset_pulse: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reflect |=> preset_done_out)
        else $error("Preset pulse missing");

    // High scale offset is the negated high half
    a_scale_high: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ev_homing_done_in && full_closed_in |=> 24'(scale_offset_high_out + $past(scale_high_in)) == 0)
        else $error("High scale offset not negated");

    // Corrected sum is zero at the home point
    a_sum_home: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (ev_homing_done_in && full_closed_in) ##1 ($stable(scale_high_in) && $stable(scale_low_in))
        |-> scale_sum == '0)
        else $error("Scale sum not zero at home");

    // Alarm stays until reset
    a_alarm_sticky: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        counter_overflow_alarm_out |=> counter_overflow_alarm_out)
        else $error("Overflow alarm dropped");

    // Portion present while ramping
    a_bl_portion: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        bl_state == HOP_BL_RAMP |=> feedback_position_out == $past(user_pos) + $past(backlash_amount_in))
        else $error("Backlash portion missing");

    // Main scenarios
    c_home: cover property (@(posedge sys_clk_in) ev_homing_done_in && home_detect_in);
    c_write_then_event: cover property (@(posedge sys_clk_in) obj_wr_in ##[1:5] reflect);
    c_ovf: cover property (@(posedge sys_clk_in) counter_overflow_alarm_out);
    c_bl: cover property (@(posedge sys_clk_in) bl_state == HOP_BL_RAMP ##1 bl_state == HOP_BL_DONE);
    c_plain_preset: cover property (@(posedge sys_clk_in) reflect && !home_detect_in);
endmodule : hop_home_offset
`default_nettype wire

/* File: tb/hop_scale_model.sv */
// Behavioural absolute scale that sits on the far side of the preset block.
// Assumes the bench loads a new 48-bit position with a one-cycle strobe.
`default_nettype none
module hop_scale_model (
    input wire logic sys_clk_in, // Control clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic load_in, // Load strobe from the bench
    input wire logic [47:0] pos_in, // New scale position
    output logic [23:0] high_out, // Scale high half
    output logic [23:0] low_out // Scale low half
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [47:0] pos; // Held scale position
    // Position register, cleared at reset
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pos <= 48'h0;
        end else if (load_in) begin
            pos <= pos_in;
        end
    end
    assign high_out = pos[47:24];
    assign low_out = pos[23:0];
endmodule : hop_scale_model
`default_nettype wire

/* File: tb/home_offset_position_preset_tb.sv */
// Self-checking bench for the home offset and position preset block.
// Assumes the scale model on the far side and one 10 MHz clock.
`default_nettype none
module home_offset_position_preset_tb import hop_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] MOTION_PROFILE_TYPE_IDX = 16'h6086; // Profile type object
    localparam logic [15:0] PROFILE_JERK_IDX = 16'h60a4; // Profile jerk object
    localparam logic [15:0] JERK_USE_SETTING_IDX = 16'h60a3; // Jerk use object
    logic clk, rstn, wr, hd, fc, rot, bsel, dchg, ld; // Bench-driven controls
    logic [15:0] idx, gear, btc; // Index, gear, time constant
    logic [31:0] wd, enc, bamt, f1; // Data, encoder, amount, sample
    logic [6:0] ev; // Event pulses
    logic [7:0] pol; // Polarity setting
    logic [47:0] spos; // Scale load value
    logic [31:0] rd, iap, idp, uap, udp, fb; // Design outputs
    logic [23:0] sh, sl, oh, ol; // Scale halves and offsets
    logic mtc, ovf, pdone; // Pulse and alarm outputs
    int error_cnt, n_checks, cyc; // Counters
    // Clock at 100 ns period
    always #50 clk = ~clk;
    hop_scale_model SCALE (.sys_clk_in(clk), .resetn_in(rstn), .load_in(ld), .pos_in(spos),
        .high_out(sh), .low_out(sl));
    hop_home_offset DUT (.sys_clk_in(clk), .resetn_in(rstn), .obj_wr_in(wr), .obj_index_in(idx),
        .obj_wdata_in(wd), .obj_rdata_out(rd), .ev_power_up_in(ev[0]), .ev_init_to_preop_in(ev[1]),
        .ev_homing_done_in(ev[2]), .ev_multiturn_clear_in(ev[3]), .ev_tool_done_in(ev[4]),
        .ev_pin_assign_in(ev[5]), .command_error_alarm_in(ev[6]), .home_detect_in(hd),
        .full_closed_in(fc), .rotary_scale_in(rot), .scale_high_in(sh), .scale_low_in(sl),
        .encoder_pos_in(enc), .gear_reverse_in(gear), .direction_polarity_in(pol),
        .backlash_select_in(bsel), .backlash_amount_in(bamt), .backlash_time_constant_in(btc),
        .dir_change_in(dchg), .internal_actual_position_out(iap), .internal_demand_position_out(idp),
        .user_actual_position_out(uap), .user_demand_position_out(udp), .feedback_position_out(fb),
        .scale_offset_high_out(oh), .scale_offset_low_out(ol), .multiturn_clear_out(mtc),
        .counter_overflow_alarm_out(ovf), .preset_done_out(pdone));
    // Wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One object write, with a gap edge after it
    task automatic obj_write(input logic [15:0] i, input logic [31:0] d);
        wr = 1'b1;
        idx = i;
        wd = d;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask : obj_write
    // One-cycle event pulse; outputs are looked at right after
    task automatic pulse(input int b);
        ev[b] = 1'b1;
        tick(1);
        ev = 7'h0;
    endtask : pulse
    // Move the scale and let the product path settle
    task automatic scale(input logic [47:0] p);
        spos = p;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        tick(4);
    endtask : scale
    // Verdict and end of run
    task automatic finish_test;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
    // Main sequence
    initial begin
        {clk, rstn, wr, hd, fc, rot, bsel, dchg, ld} = 9'h0;
        {idx, gear, btc, wd, enc, bamt, ev, pol, spos} = '0;
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        obj_write(HOME_OFFSET_VALUE_ADDR, 32'h00001234);
        check(rd, 32'h00001234);
        obj_write(16'h607d, 32'hdeadbeef);
        check(rd, 32'h00001234);
        // Profile type and jerk zeroed, then jerk use set; none touches the offset
        obj_write(MOTION_PROFILE_TYPE_IDX, 32'h0);
        obj_write(PROFILE_JERK_IDX, 32'h0);
        obj_write(JERK_USE_SETTING_IDX, 32'h1);
        check(rd, 32'h00001234);
        check(udp, 32'h0);
        enc = 32'h00000500;
        hd = 1'b1;
        pulse(0);
        check(pdone, 32'h1);
        check(iap, 32'h0);
        check(idp, 32'h0);
        check(uap, 32'h00001234);
        check(udp, 32'h00001234);
        hd = 1'b0;
        tick(1);
        // Every event but multi-turn clear, fresh offset each time
        for (int k = 0; k < 7; k++) begin
            if (k == 3) continue;
            obj_write(HOME_OFFSET_VALUE_ADDR, 32'h100 * k + 32'h7);
            enc = enc + 32'h40;
            tick(2);
            pulse(k);
            check(pdone, 32'h1);
            check(iap, enc - 32'h500);
            check(idp, enc - 32'h500);
            check(udp, enc - 32'h500 + 32'h100 * k + 32'h7);
            tick(1);
        end
        // Write and event together: old pending value applies
        {wr, idx, wd} = {1'b1, HOME_OFFSET_VALUE_ADDR, 32'h0000aaaa};
        ev[6] = 1'b1;
        tick(1);
        wr = 1'b0;
        ev = 7'h0;
        check(udp, 32'h00000180 + 32'h00000607);
        tick(1);
        pulse(4);
        check(udp, 32'h00000180 + 32'h0000aaaa);
        // Full-closed homing on the absolute scale
        {fc, rot, gear} = {1'b1, 1'b1, 16'h0003};
        scale(48'h000003_000100);
        hd = 1'b1;
        pulse(2);
        hd = 1'b0;
        check(oh, 32'h00fffffd);
        check(ol, 32'h00ffff00);
        tick(3);
        check(iap, 32'h0);
        check(uap, 32'h0000aaaa);
        scale(48'h000003_000110);
        check(iap, 32'h00000010);
        check(uap, 32'h0000aaaa + 32'h30);
        pol = POLARITY_CW;
        tick(4);
        check(uap, 32'h0000aaaa - 32'h30);
        pol = 8'h00;
        // Below the home point: negative positions, no alarm
        scale(48'h000003_0000f0);
        check(iap, 32'hfffffff0);
        check(uap, 32'h0000aaaa - 32'h30);
        check(ovf, 32'h0);
        pulse(3);
        check(mtc, 32'h1);
        rot = 1'b0;
        tick(1);
        pulse(3);
        check(mtc, 32'h0);
        // Backlash portion only while in transition
        {fc, bsel, bamt, btc} = {1'b0, 1'b1, 32'h00000050, 16'h0005};
        tick(2);
        dchg = 1'b1;
        tick(1);
        dchg = 1'b0;
        tick(2);
        f1 = fb;
        tick(3);
        check(fb, f1);
        tick(1);
        check(f1 - fb, 32'h00000050);
        // Overflow of the scale product, then sticky
        {fc, rot} = 2'b11;
        check(ovf, 32'h0);
        scale(48'h000103_000110);
        check(ovf, 32'h1);
        scale(48'h000003_000110);
        check(ovf, 32'h1);
        finish_test();
    end
endmodule : home_offset_position_preset_tb
`default_nettype wire
